//--- ccd_defines.vh
`ifndef CCD_DEFINES_VH
`define CCD_DEFINES_VH

// Register indices; byte address is four times the index
`define CCD_IDX_DIV1_CNT 10'h196
`define CCD_IDX_DIV1_CTL 10'h197
`define CCD_IDX_DIV1_ROUTE 10'h198
`define CCD_IDX_DIV21_CNT 10'h199
`define CCD_IDX_DIV2_PHASE 10'h19A
`define CCD_IDX_DIV22_CNT 10'h19B
`define CCD_IDX_DIV2_CTL 10'h19C
`define CCD_IDX_DIV2_DCC 10'h19D
`define CCD_IDX_DIV31_CNT 10'h19E
`define CCD_IDX_STATUS 10'h1F0

// Reset values
`define CCD_RST_BYTE 8'h00

// Divider 1 control and routing fields
`define CCD_D1_NOSYNC 6
`define CCD_D1_START_HI 4
`define CCD_D1_DIRECT 1
`define CCD_D1_DCC_OFF 0

// Divider 2 control and duty-correction fields
`define CCD_D22_BYPASS 5
`define CCD_D21_BYPASS 4
`define CCD_D2_NOSYNC 3
`define CCD_D2_FORCE_HI 2
`define CCD_D22_START_HI 1
`define CCD_D21_START_HI 0
`define CCD_D2_DCC_OFF 0

// Distribution source select codes
`define CCD_SRC_OSC 2'h2
`define CCD_SRC_EXT 2'h0

// Bus responses
`define CCD_RESP_OKAY 2'h0
`define CCD_RESP_SLVERR 2'h2

`endif

//--- ccd_channel_dividers.v
`timescale 1ns/1ps
`include "ccd_defines.vh"
// Function
// - Divider 1 control bit 4 sets the start level of the second LVPECL divider, low at reset.
// - Divider 1 control bits 3:0 give that divider a coarse phase offset, zero at reset.
// - With routing bit 1 at 0 the second LVPECL pair is driven by its divider.
// - With routing bit 1 at 1 the pair takes the oscillator on source 10b, the external clock on 00b, and is unchanged on 01b.
// - Routing bit 0 at 1 turns duty-cycle correction of that divider off; 0 keeps it on.
// - With correction off, divider 2.1 stays low for bits 7:4 plus one and high for bits 3:0 plus one input cycles.
// - With correction off, divider 2.2 stays low for its upper nibble plus one and high for its lower nibble plus one input cycles.
// - Divider 3.1 always has duty-cycle correction on: high for half of both nibbles plus two, rounded down, and low for the rest, in input cycles.
// - The shared phase register gives divider 2.2 its upper nibble and divider 2.1 its lower nibble.
// - Divider 2 control bit 5 bypasses divider 2.2, passing its input to its output.
// - Divider 2 control bit 4 bypasses divider 2.1, passing its input to its output.
// - Divider 2 control bit 3 makes the cascaded pair ignore the chip-level sync.
// - Divider 2 control bit 2 sets the forced pair level, which applies only with sync ignore set.
// - Divider 2 control bits 1 and 0 set the start levels of dividers 2.2 and 2.1.
// - Divider 2 correction bit 0 turns duty-cycle correction of the pair off when 1.
// - Divider 1 control bit 6 makes the second LVPECL divider ignore the chip-level sync.

module ccd_divider (
  input wire core_clk_i,
  input wire rst_i,
  input wire in_en_i,
  input wire in_lvl_i,
  input wire hold_i,
  input wire [3:0] low_cnt_i,
  input wire [3:0] high_cnt_i,
  input wire [3:0] phase_i,
  input wire start_hi_i,
  input wire bypass_i,
  input wire dcc_off_i,
  output reg div_out_o
);
  reg level;
  reg [4:0] cnt;
  reg [3:0] phase_left;
  wire [5:0] total;
  wire [4:0] hi_even;
  wire [4:0] hi_len;
  wire [4:0] lo_len;
  wire [4:0] cur_len;

  // Six bits, since both nibbles at their top give a total of 32
  assign total = {2'b00, low_cnt_i} + {2'b00, high_cnt_i} + 6'h02;
  // Correction evens out the halves; odd totals give the extra cycle low
  assign hi_even = total[5:1];
  assign hi_len = dcc_off_i ? {1'b0, high_cnt_i} + 5'h01 : hi_even;
  assign lo_len = dcc_off_i ? {1'b0, low_cnt_i} + 5'h01 :
    total[4:0] - hi_even;
  assign cur_len = level ? hi_len : lo_len;

  always @(posedge core_clk_i) begin
    if (rst_i) begin
      level <= 1'b0;
      cnt <= 5'h00;
      phase_left <= 4'h0;
      div_out_o <= 1'b0;
    end else if (bypass_i) begin
      // Divider logic idle while bypassed
      div_out_o <= in_lvl_i;
      cnt <= 5'h00;
    end else if (hold_i) begin
      level <= start_hi_i;
      cnt <= 5'h00;
      phase_left <= phase_i;
      div_out_o <= start_hi_i;
    end else begin
      div_out_o <= level;
      if (in_en_i) begin
        if (phase_left != 4'h0) begin
          phase_left <= phase_left - 4'h1;
        end else if (cnt == cur_len - 5'h01) begin
          level <= ~level;
          cnt <= 5'h00;
        end else begin
          cnt <= cnt + 5'h01;
        end
      end
    end
  end
endmodule

module ccd_channel_dividers (
  input wire core_clk_i,
  input wire rst_i,
  input wire osc_clk_i,
  input wire ext_clk_i,
  input wire sync_i,
  input wire [1:0] dist_src_sel_i,
  input wire [11:0] s_axi_awaddr_i,
  input wire s_axi_awvalid_i,
  output reg s_axi_awready_o,
  input wire [31:0] s_axi_wdata_i,
  input wire [3:0] s_axi_wstrb_i,
  input wire s_axi_wvalid_i,
  output reg s_axi_wready_o,
  output reg [1:0] s_axi_bresp_o,
  output reg s_axi_bvalid_o,
  input wire s_axi_bready_i,
  input wire [11:0] s_axi_araddr_i,
  input wire s_axi_arvalid_i,
  output reg s_axi_arready_o,
  output reg [31:0] s_axi_rdata_o,
  output reg [1:0] s_axi_rresp_o,
  output reg s_axi_rvalid_o,
  input wire s_axi_rready_i,
  output reg pecl_pair_b_out_a_o,
  output reg pecl_pair_b_out_b_o,
  output reg lvds_pair_a_out_o,
  output reg lvds_pair_b_stage1_out_o
);
  reg [7:0] div1_cycle_counts;
  reg [7:0] divider1_control;
  reg [7:0] divider1_routing;
  reg [7:0] div21_cycle_counts;
  reg [7:0] div2_phase_offsets;
  reg [7:0] div22_cycle_counts;
  reg [7:0] divider2_control;
  reg [7:0] divider2_duty_correction;
  reg [7:0] div31_cycle_counts;

  reg osc_meta;
  reg osc_sync;
  reg ext_meta;
  reg ext_sync;
  reg sync_meta;
  reg sync_lvl;
  reg dist_lvl;
  reg dist_prev;
  wire dist_en;

  wire d1_out;
  wire d21_out;
  wire d22_out;
  wire d31_out;
  reg d21_prev;
  wire d22_en;
  wire hold1;
  wire hold2;
  wire direct_hit;
  reg next_pecl;
  reg next_pair;

  reg aw_full;
  reg w_full;
  reg [9:0] aw_idx;
  reg [7:0] w_byte;
  reg w_lane0;
  reg wr_hit;
  reg [7:0] rd_byte;
  reg rd_hit;

  // Pins are asynchronous to the core clock
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      osc_meta <= 1'b0;
      osc_sync <= 1'b0;
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
      sync_meta <= 1'b0;
      sync_lvl <= 1'b0;
      dist_lvl <= 1'b0;
      dist_prev <= 1'b0;
      d21_prev <= 1'b0;
    end else begin
      osc_meta <= osc_clk_i;
      osc_sync <= osc_meta;
      ext_meta <= ext_clk_i;
      ext_sync <= ext_meta;
      sync_meta <= sync_i;
      sync_lvl <= sync_meta;
      dist_lvl <= (dist_src_sel_i == `CCD_SRC_OSC) ? osc_sync : ext_sync;
      dist_prev <= dist_lvl;
      d21_prev <= d21_out;
    end
  end

  // Each divider input cycle is one rising edge of the sampled source, or of divider 2.1's output for divider 2.2
  assign dist_en = dist_lvl & ~dist_prev;
  assign d22_en = d21_out & ~d21_prev;
  assign hold1 = sync_lvl & ~divider1_control[`CCD_D1_NOSYNC];
  assign hold2 = sync_lvl & ~divider2_control[`CCD_D2_NOSYNC];

  ccd_divider u_div1 (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .in_en_i(dist_en),
    .in_lvl_i(dist_lvl),
    .hold_i(hold1),
    .low_cnt_i(div1_cycle_counts[7:4]),
    .high_cnt_i(div1_cycle_counts[3:0]),
    .phase_i(divider1_control[3:0]),
    .start_hi_i(divider1_control[`CCD_D1_START_HI]),
    .bypass_i(1'b0),
    .dcc_off_i(divider1_routing[`CCD_D1_DCC_OFF]),
    .div_out_o(d1_out)
  );

  ccd_divider u_div21 (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .in_en_i(dist_en),
    .in_lvl_i(dist_lvl),
    .hold_i(hold2),
    .low_cnt_i(div21_cycle_counts[7:4]),
    .high_cnt_i(div21_cycle_counts[3:0]),
    .phase_i(div2_phase_offsets[3:0]),
    .start_hi_i(divider2_control[`CCD_D21_START_HI]),
    .bypass_i(divider2_control[`CCD_D21_BYPASS]),
    .dcc_off_i(divider2_duty_correction[`CCD_D2_DCC_OFF]),
    .div_out_o(d21_out)
  );

  ccd_divider u_div22 (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .in_en_i(d22_en),
    .in_lvl_i(d21_out),
    .hold_i(hold2),
    .low_cnt_i(div22_cycle_counts[7:4]),
    .high_cnt_i(div22_cycle_counts[3:0]),
    .phase_i(div2_phase_offsets[7:4]),
    .start_hi_i(divider2_control[`CCD_D22_START_HI]),
    .bypass_i(divider2_control[`CCD_D22_BYPASS]),
    .dcc_off_i(divider2_duty_correction[`CCD_D2_DCC_OFF]),
    .div_out_o(d22_out)
  );

  // Only the counts of this stage are controlled here
  ccd_divider u_div31 (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .in_en_i(dist_en),
    .in_lvl_i(dist_lvl),
    .hold_i(sync_lvl),
    .low_cnt_i(div31_cycle_counts[7:4]),
    .high_cnt_i(div31_cycle_counts[3:0]),
    .phase_i(4'h0),
    .start_hi_i(1'b0),
    .bypass_i(1'b0),
    .dcc_off_i(1'b0),
    .div_out_o(d31_out)
  );

  assign direct_hit = divider1_routing[`CCD_D1_DIRECT] &&
    (dist_src_sel_i == `CCD_SRC_OSC || dist_src_sel_i == `CCD_SRC_EXT);

  always @* begin
    // Source 01b and 11b leave the divider in charge
    next_pecl = direct_hit ? dist_lvl : d1_out;
    next_pair = d22_out;
    if (sync_lvl && divider2_control[`CCD_D2_NOSYNC]) begin
      next_pair = divider2_control[`CCD_D2_FORCE_HI];
    end
  end

  always @(posedge core_clk_i) begin
    if (rst_i) begin
      pecl_pair_b_out_a_o <= 1'b0;
      pecl_pair_b_out_b_o <= 1'b0;
      lvds_pair_a_out_o <= 1'b0;
      lvds_pair_b_stage1_out_o <= 1'b0;
    end else begin
      pecl_pair_b_out_a_o <= next_pecl;
      pecl_pair_b_out_b_o <= next_pecl;
      lvds_pair_a_out_o <= next_pair;
      lvds_pair_b_stage1_out_o <= d31_out;
    end
  end

  // Write decode on the latched word index
  always @* begin
    wr_hit = 1'b1;
    case (aw_idx)
      `CCD_IDX_DIV1_CNT, `CCD_IDX_DIV1_CTL, `CCD_IDX_DIV1_ROUTE,
      `CCD_IDX_DIV21_CNT, `CCD_IDX_DIV2_PHASE, `CCD_IDX_DIV22_CNT,
      `CCD_IDX_DIV2_CTL, `CCD_IDX_DIV2_DCC, `CCD_IDX_DIV31_CNT,
      `CCD_IDX_STATUS: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always @* begin
    rd_hit = 1'b1;
    case (s_axi_araddr_i[11:2])
      `CCD_IDX_DIV1_CNT: rd_byte = div1_cycle_counts;
      `CCD_IDX_DIV1_CTL: rd_byte = divider1_control;
      `CCD_IDX_DIV1_ROUTE: rd_byte = divider1_routing;
      `CCD_IDX_DIV21_CNT: rd_byte = div21_cycle_counts;
      `CCD_IDX_DIV2_PHASE: rd_byte = div2_phase_offsets;
      `CCD_IDX_DIV22_CNT: rd_byte = div22_cycle_counts;
      `CCD_IDX_DIV2_CTL: rd_byte = divider2_control;
      `CCD_IDX_DIV2_DCC: rd_byte = divider2_duty_correction;
      `CCD_IDX_DIV31_CNT: rd_byte = div31_cycle_counts;
      `CCD_IDX_STATUS: rd_byte = {3'h0, sync_lvl, lvds_pair_b_stage1_out_o,
        lvds_pair_a_out_o, pecl_pair_b_out_a_o, dist_lvl};
      default: begin
        rd_byte = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  // Write channel: address and data taken in either order
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o <= 1'b1;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= `CCD_RESP_OKAY;
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_idx <= 10'h000;
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
      div1_cycle_counts <= `CCD_RST_BYTE;
      divider1_control <= `CCD_RST_BYTE;
      divider1_routing <= `CCD_RST_BYTE;
      div21_cycle_counts <= `CCD_RST_BYTE;
      div2_phase_offsets <= `CCD_RST_BYTE;
      div22_cycle_counts <= `CCD_RST_BYTE;
      divider2_control <= `CCD_RST_BYTE;
      divider2_duty_correction <= `CCD_RST_BYTE;
      div31_cycle_counts <= `CCD_RST_BYTE;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_idx <= s_axi_awaddr_i[11:2];
        aw_full <= 1'b1;
        s_axi_awready_o <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_byte <= s_axi_wdata_i[7:0];
        w_lane0 <= s_axi_wstrb_i[0];
        w_full <= 1'b1;
        s_axi_wready_o <= 1'b0;
      end
      if (aw_full && w_full && !s_axi_bvalid_o) begin
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= wr_hit ? `CCD_RESP_OKAY : `CCD_RESP_SLVERR;
        aw_full <= 1'b0;
        w_full <= 1'b0;
        if (w_lane0) begin
          case (aw_idx)
            `CCD_IDX_DIV1_CNT: div1_cycle_counts <= w_byte;
            `CCD_IDX_DIV1_CTL: divider1_control <= w_byte;
            `CCD_IDX_DIV1_ROUTE: divider1_routing <= w_byte;
            `CCD_IDX_DIV21_CNT: div21_cycle_counts <= w_byte;
            `CCD_IDX_DIV2_PHASE: div2_phase_offsets <= w_byte;
            `CCD_IDX_DIV22_CNT: div22_cycle_counts <= w_byte;
            `CCD_IDX_DIV2_CTL: divider2_control <= w_byte;
            `CCD_IDX_DIV2_DCC: divider2_duty_correction <= w_byte;
            `CCD_IDX_DIV31_CNT: div31_cycle_counts <= w_byte;
            default: begin
            end
          endcase
        end
      end
      if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o <= 1'b1;
      end
    end
  end

  // Read channel answers one cycle after the address is taken
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h00000000;
      s_axi_rresp_o <= `CCD_RESP_OKAY;
    end else begin
      if (s_axi_arvalid_i && s_axi_arready_o) begin
        s_axi_arready_o <= 1'b0;
        s_axi_rvalid_o <= 1'b1;
        s_axi_rdata_o <= {24'h000000, rd_byte};
        s_axi_rresp_o <= rd_hit ? `CCD_RESP_OKAY : `CCD_RESP_SLVERR;
      end
      if (s_axi_rvalid_o && s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
        s_axi_arready_o <= 1'b1;
      end
    end
  end
endmodule

//--- ccd_channel_dividers_properties.sv
`timescale 1ns/1ps
module ccd_channel_dividers_properties (
  input wire core_clk_i,
  input wire rst_i,
  input wire s_axi_awvalid_i,
  input wire s_axi_awready_o,
  input wire s_axi_wvalid_i,
  input wire s_axi_wready_o,
  input wire [1:0] s_axi_bresp_o,
  input wire s_axi_bvalid_o,
  input wire s_axi_bready_i,
  input wire s_axi_arvalid_i,
  input wire s_axi_arready_o,
  input wire [31:0] s_axi_rdata_o,
  input wire [1:0] s_axi_rresp_o,
  input wire s_axi_rvalid_o,
  input wire s_axi_rready_i,
  input wire pecl_pair_b_out_a_o,
  input wire pecl_pair_b_out_b_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  reset_idle_a: assert property ($fell(rst_i) |-> s_axi_awready_o &&
    s_axi_wready_o && s_axi_arready_o && !s_axi_bvalid_o && !s_axi_rvalid_o)
    else $error("bus not idle after reset");
  aw_block_a: assert property (s_axi_awvalid_i && s_axi_awready_o
    |=> !s_axi_awready_o) else $error("awready not dropped");
  b_block_a: assert property (s_axi_bvalid_o |-> !s_axi_awready_o &&
    !s_axi_wready_o) else $error("ready during response");
  b_timing_a: assert property (s_axi_awvalid_i && s_axi_awready_o &&
    s_axi_wvalid_i && s_axi_wready_o |=> !s_axi_bvalid_o ##1 s_axi_bvalid_o)
    else $error("write response late");
  b_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
    s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("bresp moved");
  r_timing_a: assert property (s_axi_arvalid_i && s_axi_arready_o |=>
    s_axi_rvalid_o) else $error("read answer late");
  r_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
    s_axi_rvalid_o && $stable(s_axi_rdata_o) && $stable(s_axi_rresp_o))
    else $error("read data moved");
  r_done_a: assert property (s_axi_rvalid_o && s_axi_rready_i |=>
    !s_axi_rvalid_o) else $error("rvalid stuck");
  r_upper_a: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:8] ==
    24'h000000) else $error("upper read bits set");
  pecl_same_a: assert property (
    pecl_pair_b_out_a_o == pecl_pair_b_out_b_o) else $error("pair split");
endmodule
bind ccd_channel_dividers ccd_channel_dividers_properties u_props (
  .core_clk_i, .rst_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i,
  .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
  .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o,
  .s_axi_rvalid_o, .s_axi_rready_i, .pecl_pair_b_out_a_o,
  .pecl_pair_b_out_b_o);

//--- ccd_channel_dividers_test.sv
`timescale 1ns/1ps
`include "ccd_defines.vh"
`define CHK(nm, e, a) begin n_tests++; if ((a) !== (e)) begin n_fail++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, a); end end
module ccd_channel_dividers_test;
  logic core_clk_i = 0, rst_i = 1, osc_clk_i = 0, ext_clk_i = 0, sync_i = 0;
  logic [1:0] src = 2'h0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  // Late response ready, so the answer must stand a cycle
  logic slow = 0;
  wire awready, wready, bvalid, arready, rvalid, pa, pb, lv, l3;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [2:0] outs = {l3, lv, pa};
  int n_fail = 0, n_tests = 0, cyc = 0;
  ccd_channel_dividers u_ccd_channel_dividers (.core_clk_i, .rst_i,
    .osc_clk_i, .ext_clk_i, .sync_i, .dist_src_sel_i(src),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .pecl_pair_b_out_a_o(pa), .pecl_pair_b_out_b_o(pb),
    .lvds_pair_a_out_o(lv), .lvds_pair_b_stage1_out_o(l3));
  always #5 core_clk_i = ~core_clk_i;
  // Source clocks stay well below a quarter of the core rate
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    ext_clk_i <= cyc[2];
    osc_clk_i <= (cyc % 12) < 6;
    if (cyc == 20000) begin
      n_fail++;
      conclude;
    end
  end
  task conclude;
    $display("tests %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task wr(input [9:0] i, input [31:0] d, input [3:0] s, input [1:0] er);
    @(posedge core_clk_i);
    awaddr <= {i, 2'b00};
    wdata <= d;
    wstrb <= s;
    awvalid <= 1;
    wvalid <= 1;
    bready <= !slow;
    do begin
      @(posedge core_clk_i);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
      if (bvalid === 1'b1 && bready !== 1'b1) bready <= 1;
    end while (bvalid !== 1'b1 || bready !== 1'b1);
    bready <= 0;
    `CHK("bresp", er, bresp)
  endtask
  task w(input [9:0] i, input [7:0] d);
    wr(i, {24'h000000, d}, 4'hF, `CCD_RESP_OKAY);
  endtask
  task rd(input [9:0] i, input [7:0] e, input [1:0] er);
    @(posedge core_clk_i);
    araddr <= {i, 2'b00};
    arvalid <= 1;
    rready <= !slow;
    do begin
      @(posedge core_clk_i);
      if (arready) arvalid <= 0;
      if (rvalid === 1'b1 && rready !== 1'b1) rready <= 1;
    end while (rvalid !== 1'b1 || rready !== 1'b1);
    rready <= 0;
    `CHK("rdata", {24'h000000, e}, rdata)
    `CHK("rresp", er, rresp)
  endtask
  // Early periods may straddle a setting change, so the last one counts
  task per(input int s, input int h, input int l);
    int hi, lo;
    repeat (3) begin
      while (outs[s] !== 1'b0) @(posedge core_clk_i);
      while (outs[s] !== 1'b1) @(posedge core_clk_i);
      hi = 0;
      lo = 0;
      while (outs[s] === 1'b1) begin @(posedge core_clk_i); hi++; end
      while (outs[s] === 1'b0) begin @(posedge core_clk_i); lo++; end
    end
    `CHK("high", h, hi)
    `CHK("low", l, lo)
  endtask
  task hold(input int s, input logic e);
    repeat (20) @(posedge core_clk_i);
    `CHK("level", e, outs[s])
  endtask
  task lat(input int s, output int n);
    sync_i <= 1;
    repeat (40) @(posedge core_clk_i);
    while (cyc % 8 != 0) @(posedge core_clk_i);
    sync_i <= 0;
    n = 0;
    while (outs[s] !== 1'b1) begin @(posedge core_clk_i); n++; end
  endtask
  task t_regs;
    for (int i = 'h196; i <= 'h19E; i++)
      rd(i[9:0], 8'h00, `CCD_RESP_OKAY);
    slow = 1;
    rd(10'h100, 8'h00, `CCD_RESP_SLVERR);
    wr(10'h199, 32'hFFFFFFA5, 4'hF, `CCD_RESP_OKAY);
    slow = 0;
    wr(10'h199, 32'h0000003C, 4'h0, `CCD_RESP_OKAY);
    wr(10'h100, 32'h00000001, 4'hF, `CCD_RESP_SLVERR);
    wr(10'h1F0, 32'h000000FF, 4'hF, `CCD_RESP_OKAY);
    rd(10'h199, 8'hA5, `CCD_RESP_OKAY);
    w(10'h199, 8'h00);
    $display("t_regs done");
  endtask
  task t_route;
    per(0, 8, 8);
    w(10'h198, 8'h02);
    per(0, 4, 4);
    src <= `CCD_SRC_OSC;
    per(0, 6, 6);
    src <= 2'h1;
    per(0, 8, 8);
    src <= `CCD_SRC_EXT;
    w(10'h198, 8'h00);
    w(10'h196, 8'h30);
    per(0, 16, 24);
    w(10'h198, 8'h01);
    per(0, 8, 32);
    $display("t_route done");
  endtask
  task t_counts;
    w(10'h19C, 8'h20);
    w(10'h199, 8'h30);
    per(1, 16, 24);
    w(10'h19D, 8'h01);
    per(1, 8, 32);
    w(10'h19C, 8'h10);
    w(10'h19B, 8'h12);
    per(1, 24, 16);
    w(10'h19C, 8'h30);
    per(1, 4, 4);
    w(10'h19E, 8'h11);
    per(2, 16, 16);
    $display("t_counts done");
  endtask
  task t_sync;
    sync_i <= 1;
    w(10'h197, 8'h10);
    w(10'h19C, 8'h02);
    hold(0, 1'b1);
    hold(1, 1'b1);
    hold(2, 1'b0);
    w(10'h19C, 8'h0C);
    hold(1, 1'b1);
    w(10'h19C, 8'h0B);
    hold(1, 1'b0);
    w(10'h197, 8'h50);
    per(0, 8, 32);
    sync_i <= 0;
    $display("t_sync done");
  endtask
  task t_phase;
    int a, b;
    w(10'h197, 8'h00);
    lat(0, a);
    w(10'h197, 8'h03);
    lat(0, b);
    `CHK("phase1", 24, b - a)
    w(10'h19C, 8'h20);
    w(10'h19A, 8'hF0);
    lat(1, a);
    w(10'h19A, 8'hF5);
    lat(1, b);
    `CHK("phase21", 40, b - a)
    $display("t_phase done");
  endtask
  initial begin
    repeat (16) @(posedge core_clk_i);
    rst_i <= 0;
    t_regs;
    t_route;
    t_counts;
    t_sync;
    t_phase;
    conclude;
  end
endmodule
